// *** rtl/idc_pkg.sv ***
// Package with the constants of the idle domain controller.
package idc_pkg;
   // Number of gateable clock domains.
   localparam int unsigned NUM_DOMAINS = 6;
   // Domain bit positions inside the six-bit idle configuration.
   localparam int unsigned DOM_CPU = 0;
   localparam int unsigned DOM_MASTER = 1;
   localparam int unsigned DOM_ICACHE = 2;
   localparam int unsigned DOM_PERIPH = 3;
   localparam int unsigned DOM_CLKGEN = 4;
   localparam int unsigned DOM_EXT_MEM = 5;
   // Register offsets of the software port.
   localparam logic [3:0] OFS_IDLE_CFG = 4'h0;
   localparam logic [3:0] OFS_PERIPH_REQ = 4'h1;
   localparam logic [3:0] OFS_LEVEL = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_PERIPH_STAT = 4'h4;
   // Number of peripheral modules, host port is the last one.
   localparam int unsigned NUM_PERIPH = 4;
   localparam int unsigned PER_SERIAL = 0;
   localparam int unsigned PER_HOST = NUM_PERIPH - 1;
   // Idle level codes.
   localparam logic [1:0] LVL_NONE = 2'h0;
   localparam logic [1:0] LVL_CLK_RUNNING = 2'h1;
   localparam logic [1:0] LVL_FULL = 2'h2;
   localparam logic [1:0] LVL_FULL_OSC_OFF = 2'h3;
   // Reset values: everything active.
   localparam logic [5:0] IDLE_CFG_RST = 6'h00;
   localparam logic [3:0] PERIPH_REQ_RST = 4'h0;
endpackage : idc_pkg

// *** rtl/idc_clk_gate.sv ***
// Glitch-free clock gate with a latch that is open while the clock is low.
`timescale 1ns/1ns
`default_nettype none
module idc_clk_gate (
   input wire logic clk_i,
   input wire logic enable_i,
   output logic gclk_o
);
   // Enable copy that only changes while the clock is low.
   logic en_latch;

   // Transparent-low latch keeps the enable steady through the high phase.
   always_latch begin
      if (!clk_i) begin
         en_latch <= enable_i; // R16
      end
   end

   // Gated clock output.
   assign gclk_o = clk_i & en_latch;
endmodule : idc_clk_gate
`default_nettype wire

// *** rtl/idc_periph_idle.sv ***
// Idle handshake for one peripheral module.
`timescale 1ns/1ns
`default_nettype none
module idc_periph_idle #(
   parameter bit IMMEDIATE = 1'b0 // Idle at once, ignoring activity.
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic idle_req_i,
   input wire logic busy_i,
   input wire logic block_i,
   output logic idle_o
);
   // Idle state of this module.
   logic idle_reg;

   // Enter idle when requested and quiet, leave when request drops.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_reg <= 1'b0;
      end else if (!idle_req_i) begin
         idle_reg <= 1'b0;
      end else if (IMMEDIATE) begin
         idle_reg <= 1'b1; // R11
      end else if (!busy_i && !block_i) begin
         idle_reg <= 1'b1; // R10
      end else if (busy_i && !block_i && !idle_reg) begin
         idle_reg <= 1'b0; // R10
      end
   end

   // Idle flag output.
   assign idle_o = idle_reg;
endmodule : idc_periph_idle
`default_nettype wire

// *** rtl/idc_top.sv ***
// Idle domain controller: domain clock gating, idle levels, serial port idle.
// Operation
// (R1) Six independently gated clock domains.
// (R2) Software sets any domain combination anytime.
// (R3) Gate clocks, optionally power down generator, oscillator.
// (R4) Clock-running level idles all but clock generator.
// (R5) Full level idles every module.
// (R6) Full variant also powers oscillator down.
// (R7) External-clock serial port idles after transfer.
// (R8) Internal-clock serial port idles only if reset.
// (R9) New serial transfer wakes serial port, DMA.
// (R10) Peripherals idle after activity ends.
// (R11) Host port idles at once.
// (R12) Software checks host port idle first.
// (R13) CPU and DMA idle disable memory.
// (R14) Serial port, DMA re-idle after transfer.
// (R15) Auto wake needs clock generator active.
// (R16) Gates switch only during clock low.
`timescale 1ns/1ns
`default_nettype none
module idc_top (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [3:0] periph_busy_i,
   input wire logic serial_ext_clk_i,
   input wire logic transmitter_reset_n,
   input wire logic receiver_reset_n,
   input wire logic serial_xfer_start_i,
   input wire logic serial_xfer_done_i,
   output logic [5:0] domain_clk_o,
   output logic [5:0] domain_idle_o,
   output logic [3:0] periph_idle_o,
   output logic [3:0] periph_clk_o,
   output logic pll_pd_o,
   output logic osc_pd_o,
   output logic mem_access_en_o
);
   // Software idle configuration, one bit per domain, 1 = idle.
   logic [5:0] idle_cfg_reg;
   // Software idle request per peripheral module.
   logic [3:0] periph_req_reg;
   // Global idle level.
   logic [1:0] level_reg;
   // Automatic wake of serial port and DMA in progress.
   logic auto_wake_reg;
   // Read data register.
   logic [7:0] rdata_reg;
   // Effective domain idle vector and peripheral requests.
   logic [5:0] dom_idle;
   logic [3:0] per_req;
   logic [3:0] per_idle;
   // Serial port may not idle in internal-clock mode while out of reset.
   logic serial_block;
   // Clock generator running and usable for automatic wake.
   logic clkgen_up;

   // Decodes the two full idle levels, which stop the clock generator.
   // Used for the power-down output and to hold off an automatic wake there.
   function automatic logic is_full_level(input logic [1:0] lvl);
      return (lvl == idc_pkg::LVL_FULL) || (lvl == idc_pkg::LVL_FULL_OSC_OFF);
   endfunction : is_full_level

   // Software writes to the configuration registers.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_cfg_reg <= idc_pkg::IDLE_CFG_RST;
         periph_req_reg <= idc_pkg::PERIPH_REQ_RST;
         level_reg <= idc_pkg::LVL_NONE;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            idc_pkg::OFS_IDLE_CFG: begin
               idle_cfg_reg <= reg_wdata_i[5:0]; // R2
            end
            idc_pkg::OFS_PERIPH_REQ: begin
               periph_req_reg <= reg_wdata_i[3:0]; // R2
            end
            idc_pkg::OFS_LEVEL: begin
               level_reg <= reg_wdata_i[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Clock generator is usable only outside the full idle levels.
   assign clkgen_up = !dom_idle[idc_pkg::DOM_CLKGEN] && !pll_pd_o; // R15

   // Automatic wake: a new serial transfer wakes port and DMA, done re-idles.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         auto_wake_reg <= 1'b0;
      end else if (serial_xfer_done_i) begin
         auto_wake_reg <= 1'b0; // R14
      end else if (serial_xfer_start_i && serial_ext_clk_i && clkgen_up
                   && per_idle[idc_pkg::PER_SERIAL]
                   && idle_cfg_reg[idc_pkg::DOM_MASTER]) begin
         auto_wake_reg <= 1'b1; // R9
      end
   end

   // Domain idle vector from software and the global level.
   always_comb begin
      dom_idle = idle_cfg_reg;
      case (level_reg)
         idc_pkg::LVL_CLK_RUNNING: begin
            dom_idle = 6'h3f; // R4
            dom_idle[idc_pkg::DOM_CLKGEN] = idle_cfg_reg[idc_pkg::DOM_CLKGEN]; // R4
         end
         idc_pkg::LVL_FULL, idc_pkg::LVL_FULL_OSC_OFF: begin
            dom_idle = 6'h3f; // R5
         end
         default: begin
         end
      endcase
      // A wake never overrides a full level, since the generator is stopped there.
      if (auto_wake_reg && !is_full_level(level_reg)) begin
         dom_idle[idc_pkg::DOM_MASTER] = 1'b0; // R9
      end
   end

   // Peripheral requests follow the peripherals domain and the levels.
   always_comb begin
      per_req = periph_req_reg;
      if (dom_idle[idc_pkg::DOM_PERIPH]) begin
         per_req = 4'hf;
      end
      // The serial port wakes with the master domain, never at a full level.
      if (auto_wake_reg && !is_full_level(level_reg)) begin
         per_req[idc_pkg::PER_SERIAL] = 1'b0; // R9
      end
   end

   // Internal-clock serial port idles only with both halves in reset.
   assign serial_block = !serial_ext_clk_i
                         && (transmitter_reset_n || receiver_reset_n); // R8

   // Per-module idle handshakes; host port idles without waiting.
   for (genvar g = 0; g < idc_pkg::NUM_PERIPH; g++) begin : g_per
      idc_periph_idle #(
         .IMMEDIATE(g == idc_pkg::PER_HOST)
      ) u_idle (
         .core_clk_i(core_clk_i),
         .rstn_i(rstn_i),
         .idle_req_i(per_req[g]),
         .busy_i(periph_busy_i[g]), // R7
         .block_i((g == idc_pkg::PER_SERIAL) ? serial_block : 1'b0),
         .idle_o(per_idle[g])
      );
      // Glitch-free clock for each peripheral module.
      idc_clk_gate u_pgate (
         .clk_i(core_clk_i),
         .enable_i(!per_idle[g]),
         .gclk_o(periph_clk_o[g])
      );
   end

   // Each gate holds its enable in a latch that is open while the clock is low,
   // so a change made after a rising edge shows only from the next rising edge
   // and no domain ever sees a shortened high pulse.
   // One glitch-free gate per clock domain.
   for (genvar d = 0; d < idc_pkg::NUM_DOMAINS; d++) begin : g_dom
      idc_clk_gate u_gate (
         .clk_i(core_clk_i),
         .enable_i(!dom_idle[d]), // R1 R3
         .gclk_o(domain_clk_o[d])
      );
   end

   // Status outputs.
   assign domain_idle_o = dom_idle;
   assign periph_idle_o = per_idle;
   assign pll_pd_o = is_full_level(level_reg); // R3 R5
   assign osc_pd_o = (level_reg == idc_pkg::LVL_FULL_OSC_OFF); // R6
   assign mem_access_en_o = !(dom_idle[idc_pkg::DOM_CPU]
                              && dom_idle[idc_pkg::DOM_MASTER]); // R13

   // Read data, valid in the cycle after the read strobe.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            idc_pkg::OFS_IDLE_CFG: rdata_reg <= {2'h0, idle_cfg_reg};
            idc_pkg::OFS_PERIPH_REQ: rdata_reg <= {4'h0, periph_req_reg};
            idc_pkg::OFS_LEVEL: rdata_reg <= {6'h00, level_reg};
            idc_pkg::OFS_STATUS: rdata_reg <= {auto_wake_reg, !mem_access_en_o, dom_idle};
            idc_pkg::OFS_PERIPH_STAT: rdata_reg <= {4'h0, per_idle};
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // Rule checks. Bit 0 of the domain vector is the CPU, bit 1 the master port,
   // bit 4 the clock generator; peripheral bit 0 is the serial port, bit 3 the host port.
   // Memory disabled exactly when both CPU and DMA domains are idle.
   AST_MEM_OFF: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R13
      mem_access_en_o == !(domain_idle_o[0] && domain_idle_o[1]))
      else $error("memory enable disagrees with CPU and DMA idle");
   // Full levels idle every domain.
   AST_FULL_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R5
      pll_pd_o |-> domain_idle_o == 6'h3f)
      else $error("full idle level left a domain running");
   // Oscillator off implies generator off.
   AST_OSC: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R6
      osc_pd_o |-> pll_pd_o)
      else $error("oscillator off without full idle");
   // Clock-running level without an automatic wake keeps other domains idle.
   AST_CLK_RUN: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R4
      (level_reg == idc_pkg::LVL_CLK_RUNNING && !auto_wake_reg)
      |-> (domain_idle_o | 6'h10) == 6'h3f)
      else $error("clock-running level left a domain running");
   // Software write of the configuration takes effect next cycle.
   AST_CFG_WR: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
      (reg_wr_i && reg_addr_i == idc_pkg::OFS_IDLE_CFG)
      |=> idle_cfg_reg == $past(reg_wdata_i[5:0]))
      else $error("idle configuration write lost");
   // Host port idles one cycle after its request.
   AST_HOST: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R11
      (per_req[3] && $past(per_req[3])) |-> periph_idle_o[3])
      else $error("host port did not idle at once");
   // Busy peripheral other than the host port, not yet idle, stays awake.
   AST_BUSY: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R10
      (!periph_idle_o[1] && periph_busy_i[1]) |=> !periph_idle_o[1])
      else $error("busy peripheral entered idle");
   // Internal-clock serial port out of reset never idles.
   AST_SER_INT: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R8
      (!periph_idle_o[0] && serial_block) |=> !periph_idle_o[0])
      else $error("internal-clock serial port idled out of reset");
   // Transfer completion ends the automatic wake.
   AST_REIDLE: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R14
      serial_xfer_done_i |=> !auto_wake_reg)
      else $error("auto wake not ended after transfer");
   // A host port request idles it at the next edge, busy or not.
   AST_HOST_NOW: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R11
      per_req[3] |=> periph_idle_o[3])
      else $error("host port request not honoured at once");
   // A quiet peripheral other than the serial port idles at the next edge.
   AST_QUIET: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R10
      (per_req[1] && !periph_busy_i[1]) |=> periph_idle_o[1])
      else $error("quiet peripheral did not idle");
   // External-clock serial port idles once its transfer has ended.
   AST_SER_EXT: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R7
      (per_req[0] && serial_ext_clk_i && !periph_busy_i[0])
      |=> periph_idle_o[0])
      else $error("external-clock serial port did not idle");
   // External-clock serial port with a transfer running stays awake.
   AST_EXT_BUSY: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R7
      (!periph_idle_o[0] && periph_busy_i[0] && serial_ext_clk_i) |=> !periph_idle_o[0])
      else $error("external-clock serial port idled during a transfer");
   // Internal-clock serial port with both halves in reset idles when quiet.
   AST_SER_RST: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R8
      (per_req[0] && !serial_ext_clk_i && !transmitter_reset_n && !receiver_reset_n
       && !periph_busy_i[0]) |=> periph_idle_o[0])
      else $error("serial port with both halves in reset did not idle");
   // A dropped request, or an automatic wake outside the full levels, wakes the serial port.
   AST_SER_WAKE: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
      !per_req[0] |=> !periph_idle_o[0])
      else $error("serial port stayed idle without a request");
   // An automatic wake runs the master domain while the generator is up.
   AST_WAKE_DMA: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
      (auto_wake_reg && !pll_pd_o) |-> !domain_idle_o[1])
      else $error("automatic wake left the DMA domain idle");
   // With no level and no wake, the domains follow software exactly.
   AST_SW_CFG: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
      (level_reg == idc_pkg::LVL_NONE && !auto_wake_reg)
      |-> domain_idle_o == idle_cfg_reg)
      else $error("domain idle differs from the software configuration");
   // Without a full level the generator and the oscillator keep running.
   AST_PD_OFF: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R3
      (level_reg == idc_pkg::LVL_NONE || level_reg == idc_pkg::LVL_CLK_RUNNING)
      |-> !pll_pd_o && !osc_pd_o)
      else $error("power-down asserted outside the full levels");
   // The lowest level powers down both the generator and the oscillator.
   AST_OSC_LVL: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R6
      level_reg == idc_pkg::LVL_FULL_OSC_OFF |-> osc_pd_o && pll_pd_o)
      else $error("lowest level left the oscillator running");
   // The clock-running level leaves the generator domain to software.
   AST_CLKGEN_RUN: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R4
      level_reg == idc_pkg::LVL_CLK_RUNNING |-> domain_idle_o[4] == idle_cfg_reg[4])
      else $error("clock-running level idled the clock generator");
   // Read data stand for one cycle after a read strobe and are zero otherwise.
   AST_RD_IDLE: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside the read answer cycle");

   // Scenarios of interest.
   COV_WAKE: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      !auto_wake_reg ##1 auto_wake_reg ##[1:20] !auto_wake_reg);
   COV_OSC: cover property (@(posedge core_clk_i) disable iff (!rstn_i) osc_pd_o);
   COV_MEM: cover property (@(posedge core_clk_i) disable iff (!rstn_i) !mem_access_en_o);
   COV_SER_WAIT: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      per_req[0] && periph_busy_i[0] && !periph_idle_o[0]);
   COV_CLK_RUN: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      level_reg == idc_pkg::LVL_CLK_RUNNING);
endmodule : idc_top
`default_nettype wire

// *** dv/idc_bench.sv ***
// Self-checking bench for the idle domain controller, driven through its register port.
`timescale 1ns/1ns
`default_nettype none
module idc_bench;
   logic core_clk_i = 1'b0; // 50 MHz core clock.
   logic rstn_i = 1'b0; // Active low reset.
   logic [3:0] addr = 4'h0; // Register address.
   logic [7:0] wdata = 8'h00; // Register write data.
   logic wr = 1'b0; // Write strobe.
   logic rd = 1'b0; // Read strobe.
   logic [3:0] busy = 4'h0; // Peripheral activity levels.
   logic ext_clk = 1'b1; // Serial port clock and frame sync come from outside.
   logic tx_rn = 1'b1; // Serial transmitter out of reset.
   logic rx_rn = 1'b1; // Serial receiver out of reset.
   logic xs = 1'b0; // Serial transfer start pulse.
   logic xd = 1'b0; // Serial transfer done pulse.
   logic [7:0] rdata; // Read data.
   logic [5:0] dclk; // Gated domain clocks.
   logic [5:0] didle; // Domain idle flags.
   logic [3:0] pidle; // Peripheral idle flags.
   logic [3:0] pclk; // Gated peripheral clocks.
   logic pll_pd; // Clock generator power-down.
   logic osc_pd; // Oscillator power-down.
   logic mem_en; // Memory access enable.
   logic [7:0] v; // Scratch for read results.
   int error_cnt = 0; // Mismatches seen.
   int comparisons = 0; // Comparisons made.
   int cycles = 0; // Clock cycles run, for the hang limit.

   // The device under test.
   idc_top uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .periph_busy_i(busy), .serial_ext_clk_i(ext_clk), .transmitter_reset_n(tx_rn),
      .receiver_reset_n(rx_rn), .serial_xfer_start_i(xs), .serial_xfer_done_i(xd),
      .domain_clk_o(dclk), .domain_idle_o(didle), .periph_idle_o(pidle),
      .periph_clk_o(pclk), .pll_pd_o(pll_pd), .osc_pd_o(osc_pd), .mem_access_en_o(mem_en));

   // Clock generator, 20 ns period.
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   // Hang limit: the tests need well under a thousand cycles.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("Error at %0t ns: run did not finish", $time);
         end_sim();
      end
   end

   // Compares one result, zero-extended to eight bits.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One-cycle register write.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   // One-cycle register read; data is taken in the following cycle only.
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   // Lets n edges pass and settles into the high phase of the clock.
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step

   // Prints the end of one test.
   task automatic test_end(input string name);
      $display("Test %s done at %0t ns", name, $time);
   endtask : test_end

   // Main sequence.
   initial begin
      repeat (16) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      // Reset values, register map and three unmapped reads.
      for (int a = 0; a < 8; a++) begin
         rd_reg(a[3:0], v);
         chk(v, 8'h00, "reset read");
      end
      chk({7'h0, mem_en}, 8'h01, "memory enable after reset");
      chk({2'h0, dclk}, 8'h3f, "all domain clocks run");
      test_end("reset");
      // Each domain idled alone: only its clock stops.
      for (int i = 0; i < 6; i++) begin
         wr_reg(idc_pkg::OFS_IDLE_CFG, 8'h01 << i);
         step(2);
         chk({2'h0, didle}, 8'h01 << i, "single domain idle");
         chk({2'h0, dclk}, ~(8'h01 << i) & 8'h3f, "gated clock in high phase");
      end
      wr_reg(idc_pkg::OFS_IDLE_CFG, 8'h03);
      step(1);
      chk({7'h0, mem_en}, 8'h00, "memory off with cpu and master idle");
      rd_reg(idc_pkg::OFS_STATUS, v);
      chk(v, 8'h43, "status");
      wr_reg(4'h7, 8'h3c);
      rd_reg(idc_pkg::OFS_IDLE_CFG, v);
      chk(v, 8'h03, "unmapped write ignored, configuration kept");
      wr_reg(idc_pkg::OFS_IDLE_CFG, 8'h01);
      step(1);
      chk({7'h0, mem_en}, 8'h01, "memory on with master active");
      test_end("domains");
      // Idle levels.
      wr_reg(idc_pkg::OFS_IDLE_CFG, 8'h00);
      wr_reg(idc_pkg::OFS_LEVEL, {6'h0, idc_pkg::LVL_CLK_RUNNING});
      step(1);
      chk({2'h0, didle}, 8'h2f, "clock-running level");
      chk({6'h0, pll_pd, osc_pd}, 8'h00, "clock-running power-down");
      wr_reg(idc_pkg::OFS_LEVEL, {6'h0, idc_pkg::LVL_FULL});
      step(2);
      chk({2'h0, didle}, 8'h3f, "full level");
      chk({6'h0, pll_pd, osc_pd}, 8'h02, "full power-down");
      chk({2'h0, dclk}, 8'h00, "no clocks at full level");
      rd_reg(idc_pkg::OFS_LEVEL, v);
      chk(v, {6'h0, idc_pkg::LVL_FULL}, "level readback");
      wr_reg(idc_pkg::OFS_LEVEL, {6'h0, idc_pkg::LVL_FULL_OSC_OFF});
      step(1);
      chk({6'h0, pll_pd, osc_pd}, 8'h03, "oscillator off");
      wr_reg(idc_pkg::OFS_LEVEL, {6'h0, idc_pkg::LVL_NONE});
      step(1);
      chk({5'h0, pll_pd, osc_pd, mem_en}, 8'h01, "levels left");
      test_end("levels");
      // Peripherals: busy ones wait, the host port idles at once.
      @(posedge core_clk_i);
      busy <= 4'h2;
      wr_reg(idc_pkg::OFS_PERIPH_REQ, 8'h0e);
      step(2);
      chk({4'h0, pidle}, 8'h0c, "busy module waits, host idles");
      chk({4'h0, pclk}, 8'h03, "peripheral clocks");
      @(posedge core_clk_i);
      busy <= 4'h0;
      step(2);
      rd_reg(idc_pkg::OFS_PERIPH_STAT, v);
      chk(v, 8'h0e, "idle after activity");
      rd_reg(idc_pkg::OFS_PERIPH_REQ, v);
      chk(v, 8'h0e, "peripheral request readback");
      wr_reg(idc_pkg::OFS_PERIPH_REQ, 8'h00);
      test_end("peripherals");
      // Serial port with internal clocks idles only with both halves in reset.
      ext_clk <= 1'b0;
      wr_reg(idc_pkg::OFS_PERIPH_REQ, 8'h01);
      step(3);
      chk({7'h0, pidle[0]}, 8'h00, "internal clock, halves running");
      @(posedge core_clk_i);
      tx_rn <= 1'b0;
      rx_rn <= 1'b0;
      step(3);
      chk({7'h0, pidle[0]}, 8'h01, "internal clock, halves in reset");
      // External clocks: a transfer in progress holds idle off.
      wr_reg(idc_pkg::OFS_PERIPH_REQ, 8'h00);
      ext_clk <= 1'b1;
      busy <= 4'h1;
      wr_reg(idc_pkg::OFS_PERIPH_REQ, 8'h01);
      step(3);
      chk({7'h0, pidle[0]}, 8'h00, "external clock, busy");
      @(posedge core_clk_i);
      busy <= 4'h0;
      step(3);
      chk({7'h0, pidle[0]}, 8'h01, "external clock, done");
      test_end("serial");
      // Automatic wake and return to idle of serial port and master domain.
      wr_reg(idc_pkg::OFS_IDLE_CFG, 8'h02);
      xs <= 1'b1;
      @(posedge core_clk_i);
      xs <= 1'b0;
      step(2);
      chk({6'h0, didle[1], pidle[0]}, 8'h00, "woken");
      rd_reg(idc_pkg::OFS_STATUS, v);
      chk({7'h0, v[7]}, 8'h01, "wake flag");
      @(posedge core_clk_i);
      xd <= 1'b1;
      @(posedge core_clk_i);
      xd <= 1'b0;
      step(3);
      chk({6'h0, didle[1], pidle[0]}, 8'h03, "back to idle");
      test_end("auto wake");
      end_sim();
   end
endmodule : idc_bench
`default_nettype wire
